// File: logic/adc_seq_pkg.sv
// Constants shared by the converter sequencer and its bench.
// Assumes a 32-bit Avalon-MM slave with word addressing.
//
// Notes on behaviour
// - Writing run one starts a sequence
// - One-shot stops after four scan conversions or one select
// - Clearing run aborts at once
// - Repeat wraps 3 to 0, 7 to 4, same channel
// - Repeat cleared: finish group, then stop
// - Mode 00 low scan, 01 high, 10 select
// - Mode, channel, time fields frozen while running
// - Channel field picks select-mode input directly
// - Time field sets cycles per conversion
// - First conversion gets extra startup cycles
// - One-shot sets done flag after last result
// - Write one clears done flag
// - Repeat sets flag after channel 3, 7, select
// - Result register is channel modulo four
// - Reset clears control, timing, status registers
// - Done flag set raises interrupt request
package adc_seq_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [2:0] IDX_MAIN    = 3'h0;
    localparam logic [2:0] IDX_STATUS  = 3'h1;
    localparam logic [2:0] IDX_TIMING  = 3'h2;
    localparam logic [2:0] IDX_RESULT0 = 3'h4;

    // Field positions
    localparam int RUN_BIT    = 7;
    localparam int REPEAT_BIT = 6;
    localparam int MODE_LSB   = 4;
    localparam int SEL_LSB    = 0;
    localparam int TIME_LSB   = 0;
    localparam int FLAG_BIT   = 0;

    // Reset values
    localparam logic [7:0] MAIN_RESET   = 8'h00;
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Operating modes
    localparam logic [1:0] MODE_SCAN_LO = 2'h0;
    localparam logic [1:0] MODE_SCAN_HI = 2'h1;
    localparam logic [1:0] MODE_SELECT  = 2'h2;

    // Cycles per conversion for setting 01
    localparam int CONV_CYC_1 = 267;

    // Extra cycles for the first conversion, per time setting
    localparam int START_CYC_0 = 67;
    localparam int START_CYC_1 = 50;
    localparam int START_CYC_2 = 25;
    localparam int START_CYC_3 = 12;

endpackage : adc_seq_pkg

// File: logic/adc_sequencer_control.sv
// Control and sequencing for an 8-bit successive-approximation converter.
// Assumes the analog core presents a stable result on core_result at the
// end of each timed conversion, and a synchronous Avalon-MM master.
`timescale 1ns/100ps

module adc_sequencer_control #(
    parameter int CNT_W      = 10,
    parameter int CONV_CYC_0 = 400,
    parameter int CONV_CYC_2 = 134,
    parameter int CONV_CYC_3 = 67
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [2:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Converter core and channel selector
    output logic      [2:0]  mux_channel,
    output logic             conv_start,
    output logic             conv_active,
    input  wire logic [7:0]  core_result,
    // Completion request
    output logic             conv_done_irq
);

    typedef enum logic {ST_IDLE, ST_CONV} seq_state_e;

    // Cycles per conversion for a time setting
    function automatic logic [CNT_W-1:0] conv_cycles(input logic [1:0] t);
        unique case (t)
            2'h0: conv_cycles = CNT_W'(CONV_CYC_0);
            2'h1: conv_cycles = CNT_W'(adc_seq_pkg::CONV_CYC_1);
            2'h2: conv_cycles = CNT_W'(CONV_CYC_2);
            2'h3: conv_cycles = CNT_W'(CONV_CYC_3);
        endcase
    endfunction : conv_cycles

    // Extra cycles for the first conversion of a run
    function automatic logic [CNT_W-1:0] start_cycles(input logic [1:0] t);
        unique case (t)
            2'h0: start_cycles = CNT_W'(adc_seq_pkg::START_CYC_0);
            2'h1: start_cycles = CNT_W'(adc_seq_pkg::START_CYC_1);
            2'h2: start_cycles = CNT_W'(adc_seq_pkg::START_CYC_2);
            2'h3: start_cycles = CNT_W'(adc_seq_pkg::START_CYC_3);
        endcase
    endfunction : start_cycles

    // Refuse counts the counter cannot hold
    if (CONV_CYC_0 < 2 || CONV_CYC_2 < 2 || CONV_CYC_3 < 2 ||
        CONV_CYC_0 + adc_seq_pkg::START_CYC_0 >= (1 << CNT_W) ||
        adc_seq_pkg::CONV_CYC_1 + adc_seq_pkg::START_CYC_1 >= (1 << CNT_W) ||
        CONV_CYC_2 + adc_seq_pkg::START_CYC_2 >= (1 << CNT_W) ||
        CONV_CYC_3 + adc_seq_pkg::START_CYC_3 >= (1 << CNT_W)) begin : g_chk
        $error("conversion counts do not fit the counter");
    end

    // Control registers
    logic             run_ff;
    logic             repeat_ff;
    logic [1:0]       mode_ff;
    logic [2:0]       sel_ff;
    logic [1:0]       time_ff;
    logic             flag_ff;
    logic [7:0]       result_ff [4];
    // Sequencer
    seq_state_e       state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [2:0]       chan_ff;
    logic             start_ff;
    logic             irq_ff;
    // Bus
    logic             ack_ff;
    logic [31:0]      rdata_ff;

    logic             bus_req;
    logic             wr_en;
    logic             wr_main;
    logic             wr_timing;
    logic             wr_status;
    logic             conv_end;
    logic             group_end;
    logic             hw_stop;
    logic             begin_run;
    logic [2:0]       first_chan;
    logic [2:0]       next_chan;
    logic [7:0]       main_rd;

    // One wait state: request taken on the second cycle
    assign bus_req     = read | write;
    assign waitrequest = bus_req & ~ack_ff;
    assign wr_en       = write & ack_ff & byteenable[0];
    assign wr_main     = wr_en && address == adc_seq_pkg::IDX_MAIN;
    assign wr_timing   = wr_en && address == adc_seq_pkg::IDX_TIMING;
    assign wr_status   = wr_en && address == adc_seq_pkg::IDX_STATUS;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
        end
    end

    // Sequencing terms
    assign conv_end  = state_ff == ST_CONV && cnt_ff == '0 && run_ff;
    assign group_end = mode_ff == adc_seq_pkg::MODE_SCAN_LO ||
                       mode_ff == adc_seq_pkg::MODE_SCAN_HI
                       ? chan_ff[1:0] == 2'h3 : 1'b1;
    assign hw_stop   = conv_end && group_end && !repeat_ff;
    assign begin_run = wr_main && !run_ff &&
                       writedata[adc_seq_pkg::RUN_BIT];

    // Starting channel from the mode being written
    always_comb begin
        unique case (writedata[adc_seq_pkg::MODE_LSB +: 2])
            adc_seq_pkg::MODE_SCAN_LO: first_chan = 3'h0;
            adc_seq_pkg::MODE_SCAN_HI: first_chan = 3'h4;
            // Code 11 behaves as select mode
            default: first_chan = writedata[adc_seq_pkg::SEL_LSB +: 3];
        endcase
    end

    // Scan steps upward and wraps within its four; select repeats
    always_comb begin
        if (mode_ff == adc_seq_pkg::MODE_SCAN_LO ||
            mode_ff == adc_seq_pkg::MODE_SCAN_HI) begin
            next_chan = {chan_ff[2], chan_ff[1:0] + 2'h1};
        end else begin
            next_chan = chan_ff;
        end
    end

    // Run bit: hardware stop wins over a same-cycle write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_ff <= adc_seq_pkg::MAIN_RESET[adc_seq_pkg::RUN_BIT];
        end else if (hw_stop) begin
            run_ff <= 1'b0;
        end else if (wr_main) begin
            run_ff <= writedata[adc_seq_pkg::RUN_BIT];
        end
    end

    // Repeat bit stays writable during a run
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            repeat_ff <= adc_seq_pkg::MAIN_RESET[adc_seq_pkg::REPEAT_BIT];
        end else if (wr_main) begin
            repeat_ff <= writedata[adc_seq_pkg::REPEAT_BIT];
        end
    end

    // Mode, channel and time fields frozen while running
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_ff <= adc_seq_pkg::MAIN_RESET[adc_seq_pkg::MODE_LSB +: 2];
            sel_ff  <= adc_seq_pkg::MAIN_RESET[adc_seq_pkg::SEL_LSB +: 3];
        end else if (wr_main && !run_ff) begin
            mode_ff <= writedata[adc_seq_pkg::MODE_LSB +: 2];
            sel_ff  <= writedata[adc_seq_pkg::SEL_LSB +: 3];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            time_ff <= adc_seq_pkg::TIMING_RESET[adc_seq_pkg::TIME_LSB +: 2];
        end else if (wr_timing && !run_ff) begin
            time_ff <= writedata[adc_seq_pkg::TIME_LSB +: 2];
        end
    end

    // Done flag: a setting event wins over a clearing write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_ff <= adc_seq_pkg::STATUS_RESET[adc_seq_pkg::FLAG_BIT];
        end else if (conv_end && group_end) begin
            flag_ff <= 1'b1;
        end else if (wr_status && writedata[adc_seq_pkg::FLAG_BIT]) begin
            flag_ff <= 1'b0;
        end
    end

    // Completion pulse on the edge that sets the flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= conv_end && group_end;
        end
    end

    // Sequencer state, timer and channel
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
            chan_ff  <= 3'h0;
            start_ff <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (begin_run) begin
                        state_ff <= ST_CONV;
                        chan_ff  <= first_chan;
                        start_ff <= 1'b1;
                        cnt_ff   <= CNT_W'(conv_cycles(time_ff)
                                    + start_cycles(time_ff)
                                    - CNT_W'(1));
                    end
                end
                ST_CONV: begin
                    if (!run_ff) begin
                        state_ff <= ST_IDLE;
                    end else if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - CNT_W'(1);
                    end else if (hw_stop) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        chan_ff  <= next_chan;
                        start_ff <= 1'b1;
                        cnt_ff   <= conv_cycles(time_ff) - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // Result capture, no reset
    always_ff @(posedge clk) begin
        if (conv_end) begin
            result_ff[chan_ff[1:0]] <= core_result;
        end
    end

    // Read data captured while the request waits
    assign main_rd = {run_ff, repeat_ff, mode_ff, 1'b0, sel_ff};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (read && !ack_ff) begin
            unique case (address)
                adc_seq_pkg::IDX_MAIN:   rdata_ff <= {24'h00_0000, main_rd};
                adc_seq_pkg::IDX_STATUS: rdata_ff <= {31'h0, flag_ff};
                adc_seq_pkg::IDX_TIMING: rdata_ff <= {30'h0, time_ff};
                3'h4, 3'h5, 3'h6, 3'h7:
                    rdata_ff <= {24'h00_0000, result_ff[address[1:0]]};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign readdata      = rdata_ff;
    assign mux_channel   = chan_ff;
    assign conv_start    = start_ff;
    assign conv_active   = state_ff == ST_CONV;
    assign conv_done_irq = irq_ff;

endmodule : adc_sequencer_control

// File: test/adc_core_model.sv
// Behavioural converter core: result is 0xA0 plus the selected channel.
// Assumes conv_active marks a conversion in progress.
`timescale 1ns/100ps
module adc_core_model (
    // Clock
    input wire logic        clk,
    // Sequencer side
    input wire logic [2:0]  mux_channel,
    input wire logic        conv_active,
    output logic     [7:0]  core_result
);
    logic tog_ff = 1'b0;
    always_ff @(posedge clk) begin
        tog_ff <= ~tog_ff;
    end
    // Outside a conversion the output churns so stale sampling shows
    assign core_result = conv_active ? {5'h14, mux_channel}
                                     : ~{5'h14, mux_channel} ^ {8{tog_ff}};
endmodule : adc_core_model

// File: test/adc_sequencer_control_assertions.sv
// Port assertions for the converter sequencer, bound to its top module.
// Assumes one clock clk and synchronous active-low rst_n.
`timescale 1ns/100ps
module adc_sequencer_control_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Register bus
    input wire logic [2:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Converter side
    input wire logic [2:0]  mux_channel,
    input wire logic        conv_start,
    input wire logic        conv_active,
    input wire logic [7:0]  core_result,
    input wire logic        conv_done_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] last_ch_ff;
    always_ff @(posedge clk) begin
        if (conv_start) begin
            last_ch_ff <= mux_channel;
        end
    end
    sequence s_main_wr;
        write && !waitrequest && address == 3'h0 && byteenable[0];
    endsequence
    sequence s_chained;
        conv_start && $past(conv_active) && !$past(conv_start);
    endsequence
    property p_start;
        s_main_wr ##0 (writedata[7] && !conv_active) |=> conv_start;
    endproperty
    property p_abort;
        s_main_wr ##0 !writedata[7] |-> ##[1:2] !conv_active;
    endproperty
    property p_order;
        s_chained |-> mux_channel == last_ch_ff
            || mux_channel == {last_ch_ff[2], last_ch_ff[1:0] + 2'h1};
    endproperty
    property p_idle;
        !conv_active |-> !conv_start;
    endproperty
    property p_start_pulse;
        conv_start |=> !conv_start;
    endproperty
    property p_mux_hold;
        conv_active && !conv_start |-> $stable(mux_channel);
    endproperty
    property p_irq_pulse;
        conv_done_irq |=> !conv_done_irq;
    endproperty
    property p_irq_end;
        conv_done_irq |-> $past(conv_active) && (!conv_active || conv_start);
    endproperty
    property p_wait;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    property p_rd_width;
        read && !waitrequest |-> readdata[31:8] == 24'h0;
    endproperty
    a_start:
        assert property (p_start) else $error("run write did not start");
    a_abort:
        assert property (p_abort) else $error("run clear did not abort");
    a_order:
        assert property (p_order) else $error("channel order broken");
    a_idle:
        assert property (p_idle) else $error("start while idle");
    a_start_pulse:
        assert property (p_start_pulse) else $error("start pulse too long");
    a_mux_hold:
        assert property (p_mux_hold) else $error("channel moved mid-conversion");
    a_irq_pulse:
        assert property (p_irq_pulse) else $error("irq longer than one cycle");
    a_irq_end:
        assert property (p_irq_end) else $error("irq outside conversion end");
    a_wait:
        assert property (p_wait) else $error("waitrequest held too long");
    a_rd_width:
        assert property (p_rd_width) else $error("readdata upper bits set");
endmodule : adc_sequencer_control_chk

bind adc_sequencer_control adc_sequencer_control_chk adc_sequencer_control_chk_i (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .mux_channel(mux_channel),
    .conv_start(conv_start), .conv_active(conv_active),
    .core_result(core_result), .conv_done_irq(conv_done_irq));

// File: test/adc_sequencer_control_tb.sv
// Self-checking bench for the converter sequencer.
// Assumes the core model returns 0xA0 plus the channel.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %0h want %0h", $time, (g), (e)); end end
module adc_sequencer_control_tb;
    localparam int CYC0   = 400;
    localparam int FIRST0 = CYC0 + adc_seq_pkg::START_CYC_0;
    localparam int FIRST1 = adc_seq_pkg::CONV_CYC_1 + adc_seq_pkg::START_CYC_1;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  address = 3'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest, conv_start, conv_active, conv_done_irq;
    logic [2:0]  mux_channel;
    logic [7:0]  core_result, q, code;
    logic [2:0]  chq[$];
    int          ts[$];
    int          errors, comparisons, cyc, irqs, base, t, m, i;

    always #25 clk = ~clk;

    adc_sequencer_control #(.CONV_CYC_0(CYC0)) adc_sequencer_control_i (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest),
        .mux_channel(mux_channel), .conv_start(conv_start),
        .conv_active(conv_active), .core_result(core_result),
        .conv_done_irq(conv_done_irq));
    adc_core_model adc_core_model_i (.clk(clk), .mux_channel(mux_channel),
        .conv_active(conv_active), .core_result(core_result));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (conv_done_irq === 1'b1) irqs <= irqs + 1;
        if (conv_start === 1'b1) begin
            chq.push_back(mux_channel);
            ts.push_back(cyc);
        end
    end

    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= {24'h0, d};
        write <= w;
        read <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 20) begin errors++; give_verdict; end
    endtask : bus

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask : rd_chk

    // Kind 0 waits for irq, 1 for idle, larger for that many starts
    task automatic wait_until(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(k == 0 ? conv_done_irq === 1'b1 : k == 1 ?
                 conv_active === 1'b0 : chq.size() >= k) && n < 4000);
        t = cyc;
        if (n >= 4000) begin errors++; give_verdict; end
    endtask : wait_until

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 3; i++) rd_chk(3'(i), 8'h00);
        bus(1'b1, 3'h3, 8'hFF);
        rd_chk(3'h3, 8'h00);
        $display("test reset done");
        bus(1'b1, 3'h2, 8'h01);
        bus(1'b1, 3'h0, 8'h90);
        bus(1'b1, 3'h0, 8'hA2);
        bus(1'b1, 3'h2, 8'h00);
        rd_chk(3'h0, 8'h90);
        rd_chk(3'h2, 8'h01);
        wait_until(3);
        `CHK(ts[1] - ts[0], 317)
        `CHK(ts[2] - ts[1], 267)
        `CHK(chq[2], 3'h6)
        bus(1'b1, 3'h0, 8'h10);
        repeat (2) @(posedge clk);
        `CHK(conv_active, 1'b0)
        $display("test frozen fields and abort done");
        bus(1'b1, 3'h2, 8'h00);
        for (m = 0; m < 2; m++) begin
            chq.delete();
            bus(1'b1, 3'h0, 8'h80 | 8'(m << 4));
            wait_until(0);
            `CHK(chq.size(), 4)
            `CHK(ts[$-2] - ts[$-3], FIRST0)
            `CHK(ts[$] - ts[$-1], CYC0)
            for (i = 0; i < 4; i++) begin
                `CHK(chq[i], 3'(4 * m + i))
                rd_chk(3'h4 + 3'(i), 8'hA0 + 8'(4 * m + i));
            end
            rd_chk(3'h1, 8'h01);
        end
        bus(1'b1, 3'h2, 8'h01);
        for (i = 0; i < 8; i++) begin
            bus(1'b1, 3'h0, 8'hA0 | 8'(i));
            wait_until(0);
            `CHK(t - ts[$], FIRST1)
            `CHK(chq[$], 3'(i))
            rd_chk(3'h4 + 3'(i % 4), 8'hA0 + 8'(i));
        end
        rd_chk(3'h0, 8'h27);
        bus(1'b1, 3'h1, 8'h00);
        rd_chk(3'h1, 8'h01);
        bus(1'b1, 3'h1, 8'h01);
        rd_chk(3'h1, 8'h00);
        $display("test one-shot modes done");
        for (m = 0; m < 3; m++) begin
            chq.delete();
            base = irqs;
            code = 8'hC0 | 8'(m << 4) | (m == 2 ? 8'h06 : 8'h00);
            bus(1'b1, 3'h0, code);
            wait_until(6);
            bus(1'b1, 3'h0, code & 8'hBF);
            wait_until(1);
            rd_chk(3'h0, code & 8'h3F);
            `CHK(chq.size() % (m == 2 ? 1 : 4), 0)
            `CHK(irqs - base, m == 2 ? chq.size() : chq.size() / 4)
            for (i = 0; i < chq.size(); i++) begin
                `CHK(chq[i], m == 2 ? 3'h6 : 3'(4 * m + i % 4))
            end
        end
        $display("test continuous modes done");
        give_verdict;
    end
endmodule : adc_sequencer_control_tb
